// *** hw/pecint_pkg.sv ***
package pecint_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int PECINT_NPINS = 6;
	localparam logic [7:0] PECINT_ADDR_RISE = 8'h00;
	localparam logic [7:0] PECINT_ADDR_FALL = 8'h04;
	localparam logic [7:0] PECINT_ADDR_FLAGS = 8'h08;
	localparam logic [7:0] PECINT_ADDR_STATUS = 8'h0C;
	localparam logic [7:0] PECINT_ADDR_MASK = 8'h10;
	localparam logic [5:0] PECINT_RESET_BITS = 6'h00;
	localparam logic [1:0] PECINT_RESP_OKAY = 2'h0;
	localparam logic [1:0] PECINT_RESP_SLVERR = 2'h2;

endpackage : pecint_pkg

// *** hw/pecint_top.sv ***
`timescale 1ns/1ps
module pecint_top
	import pecint_pkg::*;
(
	// Clock, reset, enable
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic CE_I,
	// Port pins
	input wire logic [5:0] PORT_PIN_I,
	// AXI4-Lite write
	input wire logic [7:0] AWADDR_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	output logic [1:0] BRESP_O,
	output logic BVALID_O,
	input wire logic BREADY_I,
	// AXI4-Lite read
	input wire logic [7:0] ARADDR_I,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	output logic [31:0] RDATA_O,
	output logic [1:0] RRESP_O,
	output logic RVALID_O,
	input wire logic RREADY_I,
	// Events
	output logic CHANGE_SUMMARY_O,
	output logic IRQ_O
);

	// ****************************************
	// Pin synchronisers and edge detection
	// ****************************************
	logic [5:0] sync1_q;
	logic [5:0] sync2_q;
	logic [5:0] prev_q;
	logic [5:0] rise_arm_q;
	logic [5:0] fall_arm_q;
	logic [5:0] flags_q;
	logic summary_q;
	logic [1:0] status_q;
	logic [1:0] mask_q;
	logic [5:0] set_ev;

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			sync1_q <= PECINT_RESET_BITS;
			sync2_q <= PECINT_RESET_BITS;
			prev_q <= PECINT_RESET_BITS;
		end else if (CE_I) begin
			sync1_q <= PORT_PIN_I;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// One generate lane per pin: armed edges only, either direction.
	for (genvar i = 0; i < PECINT_NPINS; i++) begin : g_pin
		assign set_ev[i] = (rise_arm_q[i] & sync2_q[i] & ~prev_q[i]) |
			(fall_arm_q[i] & ~sync2_q[i] & prev_q[i]);
	end

	// ****************************************
	// AXI4-Lite handshake
	// ****************************************
	logic aw_q;
	logic w_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic wr_go;
	logic rd_go;
	logic wr_lane0;

	assign AWREADY_O = !aw_q && !bvalid_q;
	assign WREADY_O = !w_q && !bvalid_q;
	assign ARREADY_O = !rvalid_q;
	assign BVALID_O = bvalid_q;
	assign BRESP_O = bresp_q;
	assign RVALID_O = rvalid_q;
	assign RDATA_O = rdata_q;
	assign RRESP_O = rresp_q;
	assign wr_go = aw_q && w_q && !bvalid_q;
	assign rd_go = ARVALID_I && ARREADY_O && CE_I;
	assign wr_lane0 = wr_go && wstrb_q[0];

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= PECINT_RESP_OKAY;
		end else if (CE_I) begin
			if (AWVALID_I && AWREADY_O) begin
				aw_q <= 1'b1;
				awaddr_q <= AWADDR_I;
			end
			if (WVALID_I && WREADY_O) begin
				w_q <= 1'b1;
				wdata_q <= WDATA_I;
				wstrb_q <= WSTRB_I;
			end
			if (wr_go) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				bvalid_q <= 1'b1;
				case (awaddr_q)
					PECINT_ADDR_RISE, PECINT_ADDR_FALL, PECINT_ADDR_FLAGS,
					PECINT_ADDR_STATUS, PECINT_ADDR_MASK: bresp_q <= PECINT_RESP_OKAY;
					default: bresp_q <= PECINT_RESP_SLVERR;
				endcase
			end else if (bvalid_q && BREADY_I) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	// plain enables
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			rise_arm_q <= PECINT_RESET_BITS;
			fall_arm_q <= PECINT_RESET_BITS;
			mask_q <= 2'h0;
		end else if (CE_I && wr_lane0) begin
			if (awaddr_q == PECINT_ADDR_RISE) begin
				rise_arm_q <= wdata_q[5:0];
			end
			if (awaddr_q == PECINT_ADDR_FALL) begin
				fall_arm_q <= wdata_q[5:0];
			end
			if (awaddr_q == PECINT_ADDR_MASK) begin
				mask_q <= wdata_q[1:0];
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			flags_q <= PECINT_RESET_BITS;
		end else if (CE_I) begin
			if (wr_lane0 && awaddr_q == PECINT_ADDR_FLAGS) begin
				flags_q <= (flags_q & wdata_q[5:0]) | set_ev;
			end else begin
				flags_q <= flags_q | set_ev;
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			summary_q <= 1'b0;
		end else if (CE_I) begin
			summary_q <= |set_ev ? 1'b1 : |flags_q;
		end
	end
	assign CHANGE_SUMMARY_O = summary_q;

	// Status bit 0 marks an edge, bit 1 is never set; a read clears, a set wins.
	logic [1:0] status_set;
	assign status_set = {1'b0, |set_ev};
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			status_q <= 2'h0;
		end else if (CE_I) begin
			if (rd_go && ARADDR_I == PECINT_ADDR_STATUS) begin
				status_q <= status_set;
			end else begin
				status_q <= status_q | status_set;
			end
		end
	end
	assign IRQ_O = |(status_q & mask_q);

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= PECINT_RESP_OKAY;
		end else if (CE_I) begin
			if (rd_go) begin
				rvalid_q <= 1'b1;
				rresp_q <= PECINT_RESP_OKAY;
				case (ARADDR_I)
					PECINT_ADDR_RISE: rdata_q <= {26'h0, rise_arm_q};
					PECINT_ADDR_FALL: rdata_q <= {26'h0, fall_arm_q};
					PECINT_ADDR_FLAGS: rdata_q <= {26'h0, flags_q};
					PECINT_ADDR_STATUS: rdata_q <= {30'h0, status_q};
					PECINT_ADDR_MASK: rdata_q <= {30'h0, mask_q};
					default: begin
						rdata_q <= 32'h0000_0000;
						rresp_q <= PECINT_RESP_SLVERR;
					end
				endcase
			end else if (rvalid_q && RREADY_I) begin
				rvalid_q <= 1'b0;
			end
		end
	end

endmodule // pecint_top

// *** test/pecint_pins.sv ***
`timescale 1ns/1ps
module pecint_pins (
	input wire logic clk_i,
	input wire logic [5:0] lvl_i,
	output logic [5:0] pin_o
);
	initial pin_o = 6'h00;
	always @(posedge clk_i) pin_o <= lvl_i;
endmodule // pecint_pins

// *** test/pecint_checker.sv ***
`timescale 1ns/1ps
module pecint_checker (
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic CE_I,
	input wire logic [5:0] PORT_PIN_I,
	input wire logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic ARREADY_O,
	input wire logic [31:0] RDATA_O,
	input wire logic RVALID_O,
	input wire logic RREADY_I,
	input wire logic CHANGE_SUMMARY_O,
	input wire logic IRQ_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);
	chk_b_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O)
		else $error("b dropped");
	chk_b_done: assert property (BVALID_O && BREADY_I && CE_I |=> !BVALID_O)
		else $error("b stuck");
	chk_r_hold: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
		else $error("r dropped");
	chk_r_done: assert property (RVALID_O && RREADY_I && CE_I |=> !RVALID_O)
		else $error("r stuck");
	chk_ar_block: assert property (RVALID_O |-> !ARREADY_O)
		else $error("ar open");
	chk_top_zero: assert property (RVALID_O |-> RDATA_O[31:6] == 26'h0)
		else $error("high bits");
	chk_quiet_pins: assert property ((CE_I && $stable(PORT_PIN_I)) [*4] ##0 !CHANGE_SUMMARY_O
		|=> !CHANGE_SUMMARY_O) else $error("summary");
	chk_reset_clear: assert property (disable iff (1'b0) !RST_B_I
		|=> !RVALID_O && !BVALID_O && !CHANGE_SUMMARY_O && !IRQ_O) else $error("reset");
	cover property (IRQ_O);
	cover property (CHANGE_SUMMARY_O && RVALID_O);
	cover property (BVALID_O && !BREADY_I);
endmodule // pecint_checker
bind pecint_top pecint_checker u_chk (.*);

// *** test/pecint_tb_top.sv ***
`timescale 1ns/1ps
module pecint_tb_top;
	import pecint_pkg::*;
	logic clk = 0, rst_b = 0, ce = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic awr, wrd, bv, arr, rv, sum, irq;
	logic [1:0] bresp, rresp;
	logic [5:0] lvl = 0, pins, p, r, f, e;
	logic [7:0] aw = 0, ar = 0;
	logic [31:0] wd = 0, rdata, d;
	int n_fail = 0, checks_done = 0;
	always #2.5 clk = ~clk;
	pecint_pins u_pins (.clk_i(clk), .lvl_i(lvl), .pin_o(pins));
	pecint_top dut (.CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .PORT_PIN_I(pins),
		.AWADDR_I(aw), .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(4'hF),
		.WVALID_I(wv), .WREADY_O(wrd), .BRESP_O(bresp), .BVALID_O(bv), .BREADY_I(bry),
		.ARADDR_I(ar), .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rdata), .RRESP_O(rresp),
		.RVALID_O(rv), .RREADY_I(rry), .CHANGE_SUMMARY_O(sum), .IRQ_O(irq));
	function automatic logic [5:0] edges(logic [5:0] a, logic [5:0] b);
		return (~a & b & r) | (a & ~b & f);
	endfunction
	task automatic check(input logic [31:0] s, input logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			n_fail++;
			$display("ERROR %0t seen %h exp %h", $time, s, x);
		end
	endtask
	task automatic conclude();
		if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Response ready comes up at a random edge so the slave is also seen waiting.
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		aw <= a;
		wd <= v;
		awv <= 1;
		wv <= 1;
		do begin
			@(posedge clk);
			if (awr) awv <= 0;
			if (wrd) wv <= 0;
			if ($urandom % 2) bry <= 1;
		end while (!(bv && bry));
		bry <= 0;
		check(32'(bresp), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
		ar <= a;
		arv <= 1;
		do begin
			@(posedge clk);
			if (arr) arv <= 0;
			if ($urandom % 2) rry <= 1;
		end while (!(rv && rry));
		rry <= 0;
		check(rdata, x);
		check(32'(rresp), 32'(er));
	endtask
	initial begin
		void'($urandom(32'h9085171D));
		repeat (12) @(posedge clk);
		rst_b <= 1;
		@(posedge clk);
		rd(8'h14, 32'h0, PECINT_RESP_SLVERR);
		wr(8'h14, 32'h3F, PECINT_RESP_SLVERR);
		wr(PECINT_ADDR_MASK, 32'h1, 2'h0);
		repeat (12) begin
			d = $urandom;
			r = d[5:0];
			wr(PECINT_ADDR_RISE, d, 2'h0);
			d = $urandom;
			f = d[5:0];
			wr(PECINT_ADDR_FALL, d, 2'h0);
			p = pins;
			lvl <= 6'($urandom);
			repeat (7) @(posedge clk);
			e = edges(p, pins);
			check(32'(sum), 32'(|e));
			check(32'(irq), 32'(|e));
			rd(PECINT_ADDR_FLAGS, 32'(e), 2'h0);
			rd(PECINT_ADDR_STATUS, 32'(|e), 2'h0);
			wr(PECINT_ADDR_FLAGS, 32'h0, 2'h0);
			rd(PECINT_ADDR_FLAGS, 32'h0, 2'h0);
			rd(PECINT_ADDR_RISE, 32'(r), 2'h0);
			rd(PECINT_ADDR_FALL, 32'(f), 2'h0);
		end
		// Clock enable low freezes the pin pipeline; the edges land once it returns.
		wr(PECINT_ADDR_RISE, 32'h3F, 2'h0);
		wr(PECINT_ADDR_FALL, 32'h3F, 2'h0);
		ce <= 0;
		lvl <= ~pins;
		repeat (6) @(posedge clk);
		check(32'(sum), 32'h0);
		ce <= 1;
		repeat (6) @(posedge clk);
		check(32'(sum), 32'h1);
		rd(PECINT_ADDR_FLAGS, 32'h3F, 2'h0);
		// A reset in mid-run clears enables and flags just after a fresh set of edges has landed.
		lvl <= ~pins;
		repeat (5) @(posedge clk);
		rst_b <= 0;
		repeat (2) @(posedge clk);
		rst_b <= 1;
		@(posedge clk);
		check(32'(sum), 32'h0);
		rd(PECINT_ADDR_FLAGS, 32'h0, 2'h0);
		rd(PECINT_ADDR_RISE, 32'h0, 2'h0);
		rd(PECINT_ADDR_FALL, 32'h0, 2'h0);
		conclude();
	end
	initial begin
		#100us;
		n_fail++;
		conclude();
	end
endmodule // pecint_tb_top
